// [tws_top.sv]
// Two-wire slave front end with power-up sequencing and conversion pacing
`timescale 1ns/10ps
module tws_top
    import tws_pkg::*;
#(
    parameter int READY_CYC = tws_pkg::READY_DELAY_CYC,
    parameter int FRAME_CYC = tws_pkg::FRAME_CYC,
    parameter int FIFO_D    = tws_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    srst_i,
    // Two-wire pins
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe_n_o,
    // Supply monitors and recall
    input  wire logic                    digital_por_threshold_i,
    input  wire logic                    analog_por_threshold_i,
    output logic                         recall_start_o,
    input  wire logic                    recall_done_i,
    // Address configuration
    input  wire logic                    address_source_select_i,
    input  wire logic [tws_pkg::BYTE_W-1:0] prog_addr_i,
    input  wire logic                    aux_address_enable_i,
    // Memory side
    output logic                         main_sel_o,
    output logic                         aux_sel_o,
    output logic                         read_mode_o,
    output logic                         write_mode_o,
    output logic                         standby_o,
    output logic                         rx_valid_o,
    output logic [tws_pkg::BYTE_W-1:0]   rx_data_o,
    input  wire logic                    rx_ready_i,
    input  wire logic [tws_pkg::BYTE_W-1:0] tx_data_i,
    output logic                         tx_next_o,
    // Conversions and flags
    output logic                         analog_ready_n_flag_o,
    input  wire logic                    vcc_conv_done_i,
    input  wire logic                    vcc_low_i,
    output logic                         supply_low_alarm_flag_o,
    output logic                         temp_conv_start_o,
    input  wire logic                    temp_conv_done_i,
    input  wire logic [2*tws_pkg::BYTE_W-1:0] temp_result_i,
    output logic [2*tws_pkg::BYTE_W-1:0] temp_value_o
);
    localparam int RW = $clog2(READY_CYC + 1);
    localparam int FW = $clog2(FRAME_CYC + 1);
    localparam logic [RW-1:0] READY_LAST = RW'(READY_CYC);
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYC - 1);
    // Analog monitor starts low, so no recall fires on reset release
    localparam logic [3:0]    PIN_IDLE   = 4'hE;

    function automatic logic [1:0] addr_hit(input logic [7:0] b, input logic [7:0] main_a, input logic aux_on);
        addr_hit = {(b[7:1] == main_a[7:1]), aux_on && (b[7:1] == ADDR_AUX[7:1])};
    endfunction

    logic [3:0]  filt;
    logic        scl_f;
    logic        sda_f;
    logic        dpor;
    logic        apor;
    logic        scl_d_ff;
    logic        sda_d_ff;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic        por_ok;
    tws_state_e  state_ff;
    logic [3:0]  bit_cnt_ff;
    logic [7:0]  shift_ff;
    logic        sda_oe_n_ff;
    logic        mack_ff;
    logic        recalled_ff;
    logic        recall_busy_ff;
    logic [7:0]  main_addr;
    logic        aux_on;
    logic [1:0]  hit;
    logic        fifo_in_ready;
    logic        push_now;
    logic        mem_busy;
    logic        acc_begin;
    logic [RW-1:0] rdy_cnt_ff;
    logic [FW-1:0] frame_cnt_ff;
    logic        conv_pend_ff;

    // Pins and supply monitors arrive asynchronously
    tws_sync_filt #(.W(4), .FILT(FILT_LEN), .RST_VAL(PIN_IDLE)) u_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    ({scl_i, sda_i, digital_por_threshold_i, analog_por_threshold_i}),
        .filt_o     (filt)
    );

    assign {scl_f, sda_f, dpor, apor} = filt;
    assign por_ok   = dpor;
    assign scl_rise = scl_f && !scl_d_ff;
    assign scl_fall = !scl_f && scl_d_ff;
    assign start_ev = scl_f && scl_d_ff && sda_d_ff && !sda_f;
    assign stop_ev  = scl_f && scl_d_ff && !sda_d_ff && sda_f;

    // Fixed default until recall, then programmed if selected
    assign main_addr = (address_source_select_i && recalled_ff) ? prog_addr_i : ADDR_MAIN_FIXED;
    assign aux_on    = aux_address_enable_i || !recalled_ff;
    assign hit       = addr_hit(shift_ff, main_addr, aux_on);
    assign push_now  = (state_ff == ST_WR) && scl_fall && (bit_cnt_ff == BIT_LAST_DATA);
    assign mem_busy  = read_mode_o || write_mode_o;
    // Access opening this cycle: keeps a conversion from starting with it
    assign acc_begin = (state_ff == ST_ADDR) && scl_fall && (bit_cnt_ff == BIT_LAST_DATA) && (hit != 2'b00)
                       && !start_ev && !stop_ev;

    tws_fifo #(.W(BYTE_W), .DEPTH(FIFO_D)) u_fifo (
        .core_clk_i  (core_clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (push_now),
        .in_data_i   (shift_ff),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (rx_valid_o),
        .out_data_o  (rx_data_o),
        .out_ready_i (rx_ready_i)
    );

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_f;
            sda_d_ff <= sda_f;
        end
    end

    // Bus protocol engine
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !por_ok)
        begin
            state_ff     <= ST_IDLE;
            bit_cnt_ff   <= BIT_ZERO;
            shift_ff     <= '0;
            sda_oe_n_ff  <= 1'b1;
            mack_ff      <= 1'b0;
            main_sel_o   <= 1'b0;
            aux_sel_o    <= 1'b0;
            read_mode_o  <= 1'b0;
            write_mode_o <= 1'b0;
            tx_next_o    <= 1'b0;
        end
        else
        begin
            tx_next_o <= 1'b0;
            if (start_ev)
            begin
                state_ff     <= ST_ADDR;
                bit_cnt_ff   <= BIT_ZERO;
                sda_oe_n_ff  <= 1'b1;
                main_sel_o   <= 1'b0;
                aux_sel_o    <= 1'b0;
                read_mode_o  <= 1'b0;
                write_mode_o <= 1'b0;
            end
            else if (stop_ev)
            begin
                state_ff     <= ST_IDLE;
                sda_oe_n_ff  <= 1'b1;
                main_sel_o   <= 1'b0;
                aux_sel_o    <= 1'b0;
                read_mode_o  <= 1'b0;
                write_mode_o <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    ST_ADDR, ST_WR:
                    begin
                        if (scl_rise && bit_cnt_ff < BIT_LAST_DATA)
                        begin
                            shift_ff   <= {shift_ff[6:0], sda_f};
                            bit_cnt_ff <= bit_cnt_ff + 1'b1;
                        end
                        else if (scl_rise)
                            bit_cnt_ff <= BIT_ACK_DONE;
                        else if (scl_fall && bit_cnt_ff == BIT_LAST_DATA)
                        begin
                            if (state_ff == ST_ADDR && hit != 2'b00)
                            begin
                                sda_oe_n_ff  <= 1'b0;
                                main_sel_o   <= hit[1];
                                aux_sel_o    <= !hit[1];
                                read_mode_o  <= shift_ff[0];
                                write_mode_o <= !shift_ff[0];
                            end
                            else if (state_ff == ST_ADDR)
                                state_ff <= ST_IDLE;
                            else if (fifo_in_ready)
                                sda_oe_n_ff <= 1'b0;
                            else
                                state_ff <= ST_WAIT_STOP;
                        end
                        else if (scl_fall && bit_cnt_ff == BIT_ACK_DONE)
                        begin
                            bit_cnt_ff <= BIT_ZERO;
                            if (state_ff == ST_ADDR && read_mode_o)
                            begin
                                state_ff    <= ST_RD;
                                sda_oe_n_ff <= tx_data_i[7];
                                shift_ff    <= {tx_data_i[6:0], 1'b0};
                                tx_next_o   <= 1'b1;
                            end
                            else
                            begin
                                state_ff    <= ST_WR;
                                sda_oe_n_ff <= 1'b1;
                            end
                        end
                    end
                    ST_RD:
                    begin
                        if (scl_rise && bit_cnt_ff == BIT_LAST_DATA)
                        begin
                            bit_cnt_ff <= BIT_ACK_DONE;
                            mack_ff    <= !sda_f;
                        end
                        else if (scl_rise)
                            bit_cnt_ff <= bit_cnt_ff + 1'b1;
                        else if (scl_fall && bit_cnt_ff == BIT_LAST_DATA)
                            sda_oe_n_ff <= 1'b1;
                        else if (scl_fall && bit_cnt_ff == BIT_ACK_DONE)
                        begin
                            if (mack_ff)
                            begin
                                bit_cnt_ff  <= BIT_ZERO;
                                sda_oe_n_ff <= tx_data_i[7];
                                shift_ff    <= {tx_data_i[6:0], 1'b0};
                                tx_next_o   <= 1'b1;
                            end
                            else
                                state_ff <= ST_WAIT_STOP;
                        end
                        else if (scl_fall)
                        begin
                            sda_oe_n_ff <= shift_ff[7];
                            shift_ff    <= {shift_ff[6:0], 1'b0};
                        end
                    end
                    ST_WAIT_STOP:
                        sda_oe_n_ff <= 1'b1;
                    ST_IDLE:
                        sda_oe_n_ff <= 1'b1;
                    default:
                        state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // Open-drain: data flop only ever holds low
    always_ff @(posedge core_clk_i)
    begin
        sda_o      <= 1'b0;
        sda_oe_n_o <= (srst_i || !por_ok) ? 1'b1 : sda_oe_n_ff;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            standby_o <= 1'b1;
        else
            standby_o <= (state_ff == ST_IDLE) && !recall_busy_ff && !temp_conv_start_o;
    end

    // Recall once per digital power cycle
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !por_ok)
        begin
            recalled_ff    <= 1'b0;
            recall_busy_ff <= 1'b0;
            recall_start_o <= 1'b0;
        end
        else
        begin
            recall_start_o <= apor && !recalled_ff && !recall_busy_ff && !recall_start_o;
            if (recall_start_o)
                recall_busy_ff <= 1'b1;
            if (recall_busy_ff && recall_done_i)
            begin
                recall_busy_ff <= 1'b0;
                recalled_ff    <= 1'b1;
            end
        end
    end

    // Ready flag: timed fall after analog threshold
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !apor)
        begin
            rdy_cnt_ff            <= '0;
            analog_ready_n_flag_o <= 1'b1;
        end
        else if (rdy_cnt_ff == READY_LAST)
            analog_ready_n_flag_o <= 1'b0;
        else
            rdy_cnt_ff <= rdy_cnt_ff + 1'b1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || !por_ok)
            supply_low_alarm_flag_o <= 1'b1;
        else if (vcc_conv_done_i)
            supply_low_alarm_flag_o <= vcc_low_i;
    end

    // Frame pacing; a due conversion waits out memory access
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i || analog_ready_n_flag_o)
        begin
            frame_cnt_ff      <= '0;
            conv_pend_ff      <= 1'b1;
            temp_conv_start_o <= 1'b0;
        end
        else
        begin
            temp_conv_start_o <= conv_pend_ff && !mem_busy && !acc_begin;
            if (frame_cnt_ff == FRAME_LAST)
            begin
                frame_cnt_ff <= '0;
                conv_pend_ff <= 1'b1;
            end
            else
            begin
                frame_cnt_ff <= frame_cnt_ff + 1'b1;
                if (conv_pend_ff && !mem_busy && !acc_begin)
                    conv_pend_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            temp_value_o <= '0;
        else if (temp_conv_done_i)
            temp_value_o <= temp_result_i;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i || !por_ok);

    sequence s_addr_done;
        (state_ff == ST_ADDR) && scl_fall && (bit_cnt_ff == BIT_LAST_DATA) && !start_ev && !stop_ev;
    endsequence
    sequence s_match;
        s_addr_done ##0 (hit != 2'b00);
    endsequence

    chk_start_to_addr: assert property (start_ev |=> state_ff == ST_ADDR && bit_cnt_ff == BIT_ZERO)
        else $error("START did not open address phase");
    chk_stop_to_idle: assert property (stop_ev && !start_ev |=> state_ff == ST_IDLE && sda_oe_n_ff)
        else $error("STOP did not end transfer");
    chk_addr_ack: assert property (s_match |=> !sda_oe_n_ff ##1 !sda_oe_n_o)
        else $error("Matched address not acknowledged");
    chk_ack_select: assert property (s_match |=> (main_sel_o == $past(hit[1])) && (main_sel_o != aux_sel_o))
        else $error("Memory block not enabled on match");
    chk_rw_mode: assert property (s_match |=> read_mode_o == $past(shift_ff[0]) && write_mode_o != read_mode_o)
        else $error("Read/write bit mis-decoded");
    chk_nomatch_idle: assert property (s_addr_done ##0 (hit == 2'b00) |=> state_ff == ST_IDLE ##1 sda_oe_n_o)
        else $error("Unmatched address acknowledged");
    chk_default_addr: assert property (!recalled_ff |-> main_addr == ADDR_MAIN_FIXED && aux_on)
        else $error("Power-up address window wrong");
    chk_recall_kept: assert property (recalled_ff |=> recalled_ff)
        else $error("Recall lost above digital threshold");
    chk_ready_low: assert property (!apor |=> analog_ready_n_flag_o)
        else $error("Ready flag low without analog supply");
    chk_temp_pause: assert property (mem_busy |=> !temp_conv_start_o)
        else $error("Conversion started during memory access");
    chk_wait_release: assert property (state_ff == ST_WAIT_STOP |=> ##1 sda_oe_n_o)
        else $error("SDA held after master nack");
endmodule

// [tws_pkg.sv]
// Shared constants for the two-wire slave front end
package tws_pkg;
    // Bus addresses (8-bit form, bit 0 is read/write)
    localparam logic [7:0] ADDR_MAIN_FIXED = 8'hA2;
    localparam logic [7:0] ADDR_AUX        = 8'hA0;
    localparam logic [6:0] ADDR_HI_MASK    = 7'h7F;

    // Byte framing
    localparam logic [3:0] BIT_LAST_DATA   = 4'h8;
    localparam logic [3:0] BIT_ACK_DONE    = 4'h9;
    localparam logic [3:0] BIT_ZERO        = 4'h0;
    localparam int         BYTE_W          = 8;

    // Timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int READY_DELAY_US  = 1000;
    localparam int FRAME_PERIOD_US = 10000;
    localparam int READY_DELAY_CYC = (READY_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int FRAME_CYC       = (FRAME_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int FILT_LEN        = 3;
    localparam int FIFO_DEPTH      = 16;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ADDR      = 3'b001,
        ST_WR        = 3'b010,
        ST_RD        = 3'b011,
        ST_WAIT_STOP = 3'b100
    } tws_state_e;
endpackage

// [tws_sync_filt.sv]
// Two-flop synchroniser with stable-count glitch filter per bit
`timescale 1ns/10ps
module tws_sync_filt #(
    parameter int           W       = 2,
    parameter int           FILT    = 3,
    // Reset level per bit follows each input's idle state
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    // Async in, filtered out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] filt_o
);
    localparam int CW = $clog2(FILT + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(FILT);

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic          meta_ff;
            logic          sync_ff;
            logic [CW-1:0] cnt_ff;
            logic          val_ff;

            always_ff @(posedge core_clk_i)
            begin
                if (srst_i)
                begin
                    meta_ff <= RST_VAL[g];
                    sync_ff <= RST_VAL[g];
                end
                else
                begin
                    meta_ff <= async_i[g];
                    sync_ff <= meta_ff;
                end
            end

            // Short pulses never reach the edge detectors
            always_ff @(posedge core_clk_i)
            begin
                if (srst_i)
                begin
                    cnt_ff <= '0;
                    val_ff <= RST_VAL[g];
                end
                else if (sync_ff == val_ff)
                    cnt_ff <= '0;
                else if (cnt_ff == CNT_MAX)
                begin
                    cnt_ff <= '0;
                    val_ff <= sync_ff;
                end
                else
                    cnt_ff <= cnt_ff + 1'b1;
            end

            assign filt_o[g] = val_ff;
        end
    endgenerate
endmodule

// [tws_fifo.sv]
// Flop-based FIFO with registered output stage
`timescale 1ns/10ps
module tws_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         srst_i,
    // Fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // Drain side
    output logic              out_valid_o,
    output logic      [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0]   cnt_ff;
    logic          out_valid_ff;
    logic [W-1:0]  out_data_ff;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt_ff != FULL_CNT);
    assign push        = in_valid_i && in_ready_o;
    // Prefetch into the output stage whenever it is free
    assign pop         = (cnt_ff != '0) && (!out_valid_ff || out_ready_i);
    assign out_valid_o = out_valid_ff;
    assign out_data_o  = out_data_ff;

    always_ff @(posedge core_clk_i)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data_i;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= AW'((wr_ptr_ff + 1'b1) % DEPTH);
            if (pop)
                rd_ptr_ff <= AW'((rd_ptr_ff + 1'b1) % DEPTH);
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            out_valid_ff <= 1'b0;
            out_data_ff  <= '0;
        end
        else if (pop)
        begin
            out_valid_ff <= 1'b1;
            out_data_ff  <= mem_ff[rd_ptr_ff];
        end
        else if (out_ready_i)
            out_valid_ff <= 1'b0;
    end
endmodule

// [tws_bus_master.sv]
// Two-wire bus master model driving the slave front end
`timescale 1ns/10ps
module tws_bus_master (
    // Device pin side
    input  wire logic dev_d_i,
    input  wire logic dev_oe_n_i,
    // Bus wires
    output logic      scl_o,
    output logic      sda_o
);
    // Low phase 3Q, high 2Q: device answers about 8 clocks after a fall
    localparam int Q = 80;
    logic sda_m = 1'b1;
    initial scl_o = 1'b1;
    // Pull-up: a released wire reads high
    assign sda_o = sda_m & (dev_oe_n_i | dev_d_i);
    task automatic bit_x(input logic b, output logic r);
        #Q sda_m = b;
        #(2*Q) scl_o = 1'b1;
        #Q r = sda_o;
        #Q scl_o = 1'b0;
    endtask
    task automatic start();
        sda_m = 1'b1;
        #Q scl_o = 1'b1;
        #(2*Q) sda_m = 1'b0;
        #(2*Q) scl_o = 1'b0;
    endtask
    task automatic stop();
        #Q sda_m = 1'b0;
        #(2*Q) scl_o = 1'b1;
        #(2*Q) sda_m = 1'b1;
        #(2*Q);
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, ack);
    endtask
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask
endmodule

// [tws_top_tb_top.sv]
// Self-checking bench for the two-wire slave front end
`timescale 1ns/10ps
module tws_top_tb_top;
    import tws_pkg::*;
    localparam int RDY = 20;
    localparam int FRM = 64;
    logic clk = 1'b0, srst = 1'b1, dpor = 1'b1, apor = 1'b0, rdone = 1'b0, sel = 1'b1, aen = 1'b0;
    logic rx_rdy = 1'b1, vdone = 1'b0, vlow = 1'b0, tdone = 1'b0, a, e8;
    logic [7:0] paddr = 8'h5C, txd = 8'h00, rxd, d, e;
    logic [15:0] tres = 16'h0000, tval;
    logic scl, sda, sd_o, oe_n, rst_p, msel, asel, rdm, wrm, stby, rxv, txn, rdyn, alarm, tst;
    logic [7:0] q[$];
    int bad_count = 0, num_checks = 0, seed = 42, rcnt = 0, tcnt = 0;
    always #10 clk = ~clk;
    tws_top #(.READY_CYC(RDY), .FRAME_CYC(FRM), .FIFO_D(16)) tws_top_i (
        .core_clk_i(clk), .srst_i(srst), .scl_i(scl), .sda_i(sda), .sda_o(sd_o), .sda_oe_n_o(oe_n),
        .digital_por_threshold_i(dpor), .analog_por_threshold_i(apor), .recall_start_o(rst_p),
        .recall_done_i(rdone), .address_source_select_i(sel), .prog_addr_i(paddr),
        .aux_address_enable_i(aen), .main_sel_o(msel), .aux_sel_o(asel), .read_mode_o(rdm),
        .write_mode_o(wrm), .standby_o(stby), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rx_rdy),
        .tx_data_i(txd), .tx_next_o(txn), .analog_ready_n_flag_o(rdyn), .vcc_conv_done_i(vdone),
        .vcc_low_i(vlow), .supply_low_alarm_flag_o(alarm), .temp_conv_start_o(tst),
        .temp_conv_done_i(tdone), .temp_result_i(tres), .temp_value_o(tval));
    tws_bus_master tws_bus_master_i (.dev_d_i(sd_o), .dev_oe_n_i(oe_n), .scl_o(scl), .sda_o(sda));
    task automatic end_of_test();
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        num_checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic tmo(input string n, input logic ok);
        chk(n, 1, ok);
        if (ok !== 1'b1)
            end_of_test();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic adr(input logic [7:0] ad, input logic x);
        tws_bus_master_i.start();
        tws_bus_master_i.wr(ad, a);
        chk("addr ack", x, a);
    endtask
    task automatic pr(input logic s, input logic en, input logic [7:0] ad, input logic x);
        sel = s;
        aen = en;
        adr(ad, x);
        tws_bus_master_i.stop();
    endtask
    task automatic recall(input int n);
        for (int i = 0; i < 50 && rcnt < n; i++) cyc(1);
        tmo("recall", rcnt == n);
        rdone = 1'b1;
        cyc(1);
        rdone = 1'b0;
    endtask
    // Expected bytes leave the queue as the drain side takes them
    always @(posedge clk)
    begin
        if (rst_p)
            rcnt++;
        if (txn)
            tcnt++;
        if (tst && (rdm || wrm))
            chk("conv in access", 0, 1);
        if (rxv && rx_rdy)
            chk("rx byte", (q.size() > 0) ? q.pop_front() : 16'hFFFF, rxd);
    end
    initial forever
    begin
        @(posedge clk);
        if (tst)
        begin
            #1 tdone = 1'b1;
            tres = $random(seed);
            cyc(1);
            tdone = 1'b0;
            cyc(1);
            chk("temp", tres, tval);
        end
    end
    initial
    begin
        #1000000 tmo("watchdog", 1'b0);
    end
    initial
    begin
        cyc(4);
        srst = 1'b0;
        chk("reset flags", 16'h7, {oe_n, stby, rdyn} & {alarm, alarm, alarm});
        cyc(12);
        pr(1, 0, 8'hA0, 0);
        pr(1, 0, 8'h5C, 1);
        pr(1, 0, 8'h54, 1);
        pr(1, 0, 8'hA2, 0);
        chk("early recall", 0, 16'(rcnt));
        apor = 1'b1;
        recall(1);
        chk("ready early", 1, rdyn);
        for (int i = 0; i < RDY + 40 && rdyn; i++) cyc(1);
        tmo("ready", rdyn === 1'b0);
        pr(1, 0, 8'h5C, 0);
        pr(1, 0, 8'hA0, 1);
        pr(1, 1, 8'hA0, 0);
        pr(0, 1, 8'h5C, 1);
        adr(8'hA2, 0);
        chk("wr modes", 4'hA, {msel, asel, wrm, rdm});
        for (int i = 0; i < 3; i++)
        begin
            d = $random(seed);
            q.push_back(d);
            tws_bus_master_i.wr(d, a);
            chk("data ack", 0, a);
        end
        tws_bus_master_i.stop();
        cyc(12);
        chk("after stop", 5'h10, {stby, msel, asel, wrm, rdm});
        txd = $random(seed);
        adr(8'hA3, 0);
        chk("rd modes", 4'h9, {msel, asel, wrm, rdm});
        for (int i = 0; i < 2; i++)
        begin
            e = txd;
            tws_bus_master_i.rd(i == 1, d);
            txd = $random(seed);
            chk("rd byte", e, d);
        end
        tws_bus_master_i.stop();
        chk("tx next", 2, 16'(tcnt));
        chk("alarm default", 1, alarm);
        for (int v = 0; v < 2; v++)
        begin
            vlow = v[0];
            vdone = 1'b1;
            cyc(1);
            vdone = 1'b0;
            cyc(2);
            chk("alarm", v, alarm);
        end
        rx_rdy = 1'b0;
        adr(8'hA2, 0);
        for (int i = 0; i < 18; i++)
        begin
            d = $random(seed);
            tws_bus_master_i.wr(d, a);
            if (a === 1'b0)
                q.push_back(d);
            if (i < 16 || i == 17)
                chk("fill ack", i == 17, a);
        end
        tws_bus_master_i.stop();
        rx_rdy = 1'b1;
        for (int i = 0; i < 60 && q.size() > 0; i++) cyc(1);
        tmo("drain", q.size() == 0);
        apor = 1'b0;
        cyc(12);
        chk("ready dip", 1, rdyn);
        apor = 1'b1;
        cyc(RDY + 40);
        chk("no recall", 1, 16'(rcnt));
        chk("ready again", 0, rdyn);
        dpor = 1'b0;
        cyc(12);
        dpor = 1'b1;
        cyc(12);
        pr(1, 0, 8'h5C, 1);
        recall(2);
        pr(1, 0, 8'h5C, 0);
        end_of_test();
    end
endmodule
